// *** core/pic_regs.sv ***
// Interrupt control/status and PHY control register slice.
// Assumes a management front end giving address, read and write
// strobes; status inputs from PHY logic on clk; straps are pins.
`timescale 1ns/100ps
module pic_regs #(
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Register access
    input  wire logic [4:0]    reg_addr,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [DW-1:0] reg_wdata,
    output logic      [DW-1:0] reg_rdata,
    // Events from PHY logic, single-cycle pulses
    input  wire logic          evt_lp_ack,
    input  wire logic          evt_link_down,
    input  wire logic          evt_remote_fault,
    input  wire logic          evt_link_up,
    // Status from PHY logic
    input  wire logic          energy_detect,
    input  wire logic          an_complete,
    input  wire logic          pause_result,
    input  wire logic          phy_isolated,
    input  wire logic          link_100,
    input  wire logic          link_full,
    // Strap pins, asynchronous
    input  wire logic          strap_pwr_save,
    input  wire logic          strap_pairswap_dis,
    input  wire logic          strap_scramble_dis,
    // Control outputs
    output logic               crossover_dis,
    output logic               force_link,
    output logic               power_save_en,
    output logic               jabber_en,
    output logic               sqe_test_en,
    output logic               scrambler_bypass,
    output logic               int_pin
);
    ////////////////////////////////////////////////////////////////////
    // Decode
    wire sel_int = (reg_addr == pic_pkg::ADDR_INT_CTRL_STAT);
    wire sel_pc  = (reg_addr == pic_pkg::ADDR_PHY_CTRL_STAT);
    wire wr_int  = reg_wr & sel_int;
    wire wr_pc   = reg_wr & sel_pc;
    wire rd_int  = reg_rd & sel_int;

    ////////////////////////////////////////////////////////////////////
    // Strap capture after reset release
    logic [2:0] strap_s;
    logic       strap_pend_r;
    logic       strap_cnt_r;

    pic_sync3 #(.W(3)) u_strap_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({strap_pwr_save, strap_pairswap_dis, strap_scramble_dis}),
        .dout (strap_s)
    );

    // Filtered value valid a few edges after release
    logic [2:0] strap_wait_r;
    wire        strap_load = strap_pend_r & (strap_wait_r == 3'h5);

    always_ff @(posedge clk) begin
        if (rst) begin
            strap_pend_r <= 1'b1;
            strap_wait_r <= 3'h0;
        end else if (strap_pend_r) begin
            strap_wait_r <= strap_wait_r + 3'h1;
            if (strap_load) begin
                strap_pend_r <= 1'b0;
            end
        end
    end
    assign strap_cnt_r = strap_pend_r;

    ////////////////////////////////////////////////////////////////////
    // Event flags
    logic [3:0] flag;
    wire  [3:0] evt = {evt_lp_ack, evt_link_down,
                       evt_remote_fault, evt_link_up};

    genvar gi;
    generate
        for (gi = 0; gi < pic_pkg::INT_NUM_FLAGS; gi++) begin : g_flag
            pic_flag u_flag (
                .clk    (clk),
                .rst    (rst),
                .evt    (evt[gi]),
                .rd_clr (rd_int),
                .flag_r (flag[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Writable fields
    logic [3:0] int_en_r;
    logic       pairswap_r, force_r, psave_r, level_r;
    logic       jab_r, sqe_r, scr_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            int_en_r <= pic_pkg::RST_INT_EN;
        end else if (wr_int) begin
            int_en_r <= reg_wdata[pic_pkg::INT_EN_LSB +: 4];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pairswap_r <= pic_pkg::RST_PAIRSWAP_DIS;
            force_r    <= pic_pkg::RST_FORCE_LINK;
            psave_r    <= pic_pkg::RST_PWR_SAVE;
            level_r    <= pic_pkg::RST_INT_LEVEL;
            jab_r      <= pic_pkg::RST_JABBER_EN;
            sqe_r      <= pic_pkg::RST_SQE_TEST;
            scr_r      <= pic_pkg::RST_SCRAMBLE_DIS;
        end else if (strap_load) begin
            psave_r    <= strap_s[2];
            pairswap_r <= strap_s[1];
            scr_r      <= strap_s[0];
        end else if (wr_pc) begin
            pairswap_r <= reg_wdata[pic_pkg::PC_PAIRSWAP_DIS];
            force_r    <= reg_wdata[pic_pkg::PC_FORCE_LINK];
            psave_r    <= reg_wdata[pic_pkg::PC_PWR_SAVE];
            level_r    <= reg_wdata[pic_pkg::PC_INT_LEVEL];
            jab_r      <= reg_wdata[pic_pkg::PC_JABBER_EN];
            sqe_r      <= reg_wdata[pic_pkg::PC_SQE_TEST];
            scr_r      <= reg_wdata[pic_pkg::PC_SCRAMBLE_DIS];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operating state indication
    logic [2:0] mode;
    always_comb begin
        if (phy_isolated) begin
            mode = pic_pkg::MODE_ISOLATE;
        end else if (!an_complete) begin
            mode = pic_pkg::MODE_AUTONEG;
        end else begin
            mode = {link_full, link_100, ~link_100};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data
    logic [DW-1:0] int_word;
    logic [DW-1:0] pc_word;
    always_comb begin
        int_word = '0;
        int_word[pic_pkg::INT_FLAG_LSB +: 4] = flag;
        int_word[pic_pkg::INT_EN_LSB +: 4]   = int_en_r;
        pc_word = '0;
        pc_word[pic_pkg::PC_PAIRSWAP_DIS] = pairswap_r;
        pc_word[pic_pkg::PC_ENERGY]       = energy_detect;
        pc_word[pic_pkg::PC_FORCE_LINK]   = force_r;
        pc_word[pic_pkg::PC_PWR_SAVE]     = psave_r;
        pc_word[pic_pkg::PC_INT_LEVEL]    = level_r;
        pc_word[pic_pkg::PC_JABBER_EN]    = jab_r;
        pc_word[pic_pkg::PC_AN_DONE]      = an_complete;
        pc_word[pic_pkg::PC_PAUSE]        = pause_result;
        pc_word[pic_pkg::PC_ISOLATE]      = phy_isolated;
        pc_word[pic_pkg::PC_MODE_LSB +: 3] = mode;
        pc_word[pic_pkg::PC_SQE_TEST]     = sqe_r;
        pc_word[pic_pkg::PC_SCRAMBLE_DIS] = scr_r;
    end

    wire [DW-1:0] rdata_nxt = sel_int ? int_word :
                              sel_pc  ? pc_word  : '0;

    ////////////////////////////////////////////////////////////////////
    // Interrupt pin and registered outputs
    wire int_any = |(flag & int_en_r);
    wire int_nxt = level_r ? int_any : ~int_any;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata        <= '0;
            crossover_dis    <= pic_pkg::RST_PAIRSWAP_DIS;
            force_link       <= pic_pkg::RST_FORCE_LINK;
            power_save_en    <= pic_pkg::RST_PWR_SAVE;
            jabber_en        <= pic_pkg::RST_JABBER_EN;
            sqe_test_en      <= pic_pkg::RST_SQE_TEST;
            scrambler_bypass <= pic_pkg::RST_SCRAMBLE_DIS;
            int_pin          <= 1'b1;
        end else begin
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
            crossover_dis    <= pairswap_r;
            force_link       <= force_r;
            power_save_en    <= psave_r;
            jabber_en        <= jab_r;
            sqe_test_en      <= sqe_r;
            scrambler_bypass <= scr_r;
            int_pin          <= int_nxt;
        end
    end
endmodule : pic_regs

// *** common/pic_pkg.sv ***
// Shared constants for the interrupt and PHY control register slice.
// Assumes a 5-bit management register address and 16-bit data.
package pic_pkg;
    localparam logic [4:0]  ADDR_INT_CTRL_STAT = 5'h1B;
    localparam logic [4:0]  ADDR_PHY_CTRL_STAT = 5'h1F;
    // Interrupt register field positions
    localparam int          INT_FLAG_LSB       = 0;
    localparam int          INT_EN_LSB         = 8;
    localparam int          INT_NUM_FLAGS      = 4;
    // PHY control register bit positions
    localparam int          PC_PAIRSWAP_DIS    = 13;
    localparam int          PC_ENERGY          = 12;
    localparam int          PC_FORCE_LINK      = 11;
    localparam int          PC_PWR_SAVE        = 10;
    localparam int          PC_INT_LEVEL       = 9;
    localparam int          PC_JABBER_EN       = 8;
    localparam int          PC_AN_DONE         = 7;
    localparam int          PC_PAUSE           = 6;
    localparam int          PC_ISOLATE         = 5;
    localparam int          PC_MODE_LSB        = 2;
    localparam int          PC_SQE_TEST        = 1;
    localparam int          PC_SCRAMBLE_DIS    = 0;
    // Reset values of writable bits without strap override
    localparam logic [3:0]  RST_INT_EN         = 4'h0;
    localparam logic        RST_PAIRSWAP_DIS   = 1'b0;
    localparam logic        RST_FORCE_LINK     = 1'b0;
    localparam logic        RST_PWR_SAVE       = 1'b1;
    localparam logic        RST_INT_LEVEL      = 1'b0;
    localparam logic        RST_JABBER_EN      = 1'b1;
    localparam logic        RST_SQE_TEST       = 1'b0;
    localparam logic        RST_SCRAMBLE_DIS   = 1'b0;
    // Operating state encodings
    localparam logic [2:0]  MODE_AUTONEG       = 3'h0;
    localparam logic [2:0]  MODE_10_HALF       = 3'h1;
    localparam logic [2:0]  MODE_100_HALF      = 3'h2;
    localparam logic [2:0]  MODE_RESERVED      = 3'h3;
    localparam logic [2:0]  MODE_10_FULL       = 3'h5;
    localparam logic [2:0]  MODE_100_FULL      = 3'h6;
    localparam logic [2:0]  MODE_ISOLATE       = 3'h7;
endpackage : pic_pkg

// *** core/pic_sync3.sv ***
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module pic_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire  [W-1:0] agree = ~(s2_r ^ s3_r);
    wire  [W-1:0] dout_nxt = (agree & s3_r) | (~agree & dout);

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= dout_nxt;
        end
    end
endmodule : pic_sync3

// *** core/pic_flag.sv ***
// One self-clearing event flag: set on event, cleared by a read.
// Assumes event and read strobe are single-cycle, on clk.
`timescale 1ns/100ps
module pic_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic evt,
    input  wire logic rd_clr,
    // Status
    output logic      flag_r
);
    // Set beats clear in the same cycle
    wire flag_nxt = evt | (flag_r & ~rd_clr);

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule : pic_flag

// *** tb/pic_regs_asserts.sv ***
// Checker for the interrupt and PHY control register slice.
// Sees only the pic_regs ports; bound after the module.
`timescale 1ns/100ps
module pic_regs_asserts #(
    parameter int DW = 16
) (
    // Clock, reset and register access
    input wire logic          clk, rst, reg_wr, reg_rd,
    input wire logic [4:0]    reg_addr,
    input wire logic [DW-1:0] reg_wdata, reg_rdata,
    // Status and control
    input wire logic energy_detect, an_complete, pause_result,
    input wire logic phy_isolated, link_100, link_full,
    input wire logic force_link, power_save_en, jabber_en,
    input wire logic scrambler_bypass
);
    localparam logic [4:0] A1B = pic_pkg::ADDR_INT_CTRL_STAT;
    localparam logic [4:0] A1F = pic_pkg::ADDR_PHY_CTRL_STAT;
    wire [5:0] st = {energy_detect, an_complete, pause_result,
                     phy_isolated, link_100, link_full};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Lone write to the control register
    sequence s_w;
        (reg_wr && reg_addr == A1F) ##1 !(reg_wr && reg_addr == A1F);
    endsequence
    // Read of the control register with steady status
    sequence s_r;
        ($stable(st) && reg_rd && reg_addr == A1F) ##1 $stable(st);
    endsequence
    property p_force;
        s_w |=> force_link == $past(reg_wdata[11], 2);
    endproperty
    a_force: assert property (p_force) else $error("force link");
    property p_pwr;
        s_w |=> power_save_en == $past(reg_wdata[10], 2);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power save");
    property p_jab;
        s_w |=> jabber_en == $past(reg_wdata[8], 2);
    endproperty
    a_jab: assert property (p_jab) else $error("jabber");
    property p_scr;
        s_w |=> scrambler_bypass == $past(reg_wdata[0], 2);
    endproperty
    a_scr: assert property (p_scr) else $error("scrambler");
    property p_stat;
        s_r |-> {reg_rdata[12], reg_rdata[7:5]} == st[5:2];
    endproperty
    a_stat: assert property (p_stat) else $error("status");
    property p_mode;
        s_r |-> reg_rdata[4:2] == (st[2] ? 3'h7 : !st[4] ? 3'h0 :
                                   {st[0], st[1], !st[1]});
    endproperty
    a_mode: assert property (p_mode) else $error("mode field");
    property p_rsv1f;
        reg_rd && reg_addr == A1F |=> reg_rdata[15:14] == 2'h0;
    endproperty
    a_rsv1f: assert property (p_rsv1f) else $error("reserved");
    property p_rsv1b;
        reg_rd && reg_addr == A1B |=>
            reg_rdata[15:12] == 4'h0 && reg_rdata[7:4] == 4'h0;
    endproperty
    a_rsv1b: assert property (p_rsv1b) else $error("int bits");
    c_wr: cover property (s_w);
    c_rd: cover property (s_r);
    c_rd1b: cover property (reg_rd && reg_addr == A1B);
endmodule : pic_regs_asserts
bind pic_regs pic_regs_asserts #(.DW(DW)) u_pic_regs_asserts (.*);

// *** tb/pic_mgmt_model.sv ***
// Management master model driving the register access port.
// Assumes requests are taken at the rising clock edge.
`timescale 1ns/100ps
module pic_mgmt_model (
    // Clock
    input  wire logic        clk,
    // Register access
    output logic      [4:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // One-cycle strobe, then lines move away from the old value
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask : rd
endmodule : pic_mgmt_model

// *** tb/tb_pic_regs.sv ***
// Testbench for the interrupt and PHY control register slice.
// Straps are held steady; status levels change off the read edge.
`timescale 1ns/100ps
module tb_pic_regs;
    logic clk = 1'b0, rst = 1'b1;
    logic [4:0] reg_addr;
    logic reg_wr, reg_rd, int_pin;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [3:0] evt = 4'h0;
    logic energy_detect = 1'b1, an_complete = 1'b1, pause_result = 1'b0;
    logic phy_isolated = 1'b0, link_100 = 1'b1, link_full = 1'b1;
    logic strap_pwr_save = 1'b0, strap_pairswap_dis = 1'b1;
    logic strap_scramble_dis = 1'b1;
    logic crossover_dis, force_link, power_save_en, jabber_en;
    logic sqe_test_en, scrambler_bypass;
    wire [5:0] outs = {crossover_dis, force_link, power_save_en,
                       jabber_en, sqe_test_en, scrambler_bypass};
    int fails = 0, n_compared = 0, cyc = 0;
    logic [6:0] tbl [6] = '{7'h00, 7'h21, 7'h32, 7'h2D, 7'h3E, 7'h7F};
    pic_regs u_pic_regs (.evt_lp_ack(evt[3]), .evt_link_down(evt[2]),
        .evt_remote_fault(evt[1]), .evt_link_up(evt[0]), .*);
    pic_mgmt_model u_pic_mgmt_model (.*);
    always #20 clk = ~clk;
    task automatic stop_test;
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            stop_test;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic t_reset;
        u_pic_mgmt_model.rd(5'h1F, d);
        chk(d, 16'h3199);
        chk(outs, 6'h25);
        u_pic_mgmt_model.rd(5'h1B, d);
        chk(d, 16'h0000);
        chk(int_pin, 1'b1);
    endtask : t_reset
    task automatic t_ctl;
        u_pic_mgmt_model.wr(5'h1F, 16'hFFFF);
        u_pic_mgmt_model.rd(5'h1F, d);
        chk(d, 16'h3F9B);
        chk(outs, 6'h3F);
        chk(int_pin, 1'b0);
        u_pic_mgmt_model.wr(5'h1F, 16'h0000);
        u_pic_mgmt_model.rd(5'h1F, d);
        chk(d, 16'h1098);
        chk(outs, 6'h00);
        chk(int_pin, 1'b1);
    endtask : t_ctl
    task automatic t_unmapped;
        u_pic_mgmt_model.wr(5'h05, 16'hFFFF);
        u_pic_mgmt_model.rd(5'h05, d);
        chk(d, 16'h0000);
        u_pic_mgmt_model.rd(5'h1F, d);
        chk(d, 16'h1098);
    endtask : t_unmapped
    task automatic t_flags;
        for (int i = 0; i < 4; i++) begin
            u_pic_mgmt_model.wr(5'h1B, 16'h0100 << i);
            @(posedge clk);
            evt <= 4'h1 << i;
            @(posedge clk);
            evt <= 4'h0;
            repeat (3) @(posedge clk);
            #1 chk(int_pin, 1'b0);
            u_pic_mgmt_model.rd(5'h1B, d);
            chk(d, (16'h0100 << i) | (16'h1 << i));
            u_pic_mgmt_model.rd(5'h1B, d);
            chk(d, 16'h0100 << i);
            chk(int_pin, 1'b1);
        end
        u_pic_mgmt_model.wr(5'h1B, 16'h0000);
        @(posedge clk);
        evt <= 4'hF;
        @(posedge clk);
        evt <= 4'h0;
        repeat (3) @(posedge clk);
        #1 chk(int_pin, 1'b1);
        u_pic_mgmt_model.rd(5'h1B, d);
        chk(d, 16'h000F);
    endtask : t_flags
    task automatic t_mode;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            {phy_isolated, an_complete, link_100, link_full} <= tbl[i][6:3];
            energy_detect <= i[0];
            pause_result <= i[1];
            u_pic_mgmt_model.rd(5'h1F, d);
            chk({d[12], d[7:2]}, {i[0], tbl[i][5], i[1], tbl[i][6],
                tbl[i][2:0]});
        end
    endtask : t_mode
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        t_reset;
        t_ctl;
        t_unmapped;
        t_flags;
        t_mode;
        stop_test;
    end
endmodule : tb_pic_regs
